// ---- cnmr_can_master.sv ----
// Behavioural CAN network master: sends request frames and takes reply frames
`timescale 1ns/1ps
`default_nettype none
module cnmr_can_master (
  input  wire logic        mclk,
  input  wire logic        slow,
  output logic             rx_valid,
  output logic [10:0]      rx_id,
  output logic             rx_rtr,
  output logic [3:0]       rx_dlc,
  output logic [63:0]      rx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [10:0] tx_id,
  input  wire logic [3:0]  tx_dlc,
  input  wire logic [63:0] tx_data
);
  int          wait_cyc = 0;
  int          n_rx = 0;
  time         t_rx = 0;
  logic [10:0] got_id = 11'h0;
  logic [3:0]  got_dlc = 4'h0;
  logic [63:0] got_data = 64'h0;

  initial begin
    rx_valid = 1'b0;
    rx_id = 11'h0;
    rx_rtr = 1'b0;
    rx_dlc = 4'h0;
    rx_data = 64'h0;
  end

  // Slow mode stalls every reply three cycles
  assign tx_ready = !slow || wait_cyc >= 3;

  always @(posedge mclk) begin
    if (tx_valid && tx_ready) begin
      n_rx <= n_rx + 1;
      t_rx <= $time;
      got_id <= tx_id;
      got_dlc <= tx_dlc;
      got_data <= tx_data;
    end
    wait_cyc <= (tx_valid && !tx_ready) ? wait_cyc + 1 : 0;
  end

  // One frame a call, held for one edge
  task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc,
                      input logic [63:0] data);
    @(posedge mclk);
    #1;
    rx_valid = 1'b1;
    rx_id = id;
    rx_rtr = rtr;
    rx_dlc = dlc;
    rx_data = data;
    @(posedge mclk);
    #1;
    rx_valid = 1'b0;
    // Inverted leftovers so a stale payload never looks live
    rx_id = ~id;
    rx_rtr = ~rtr;
    rx_dlc = ~dlc;
    rx_data = ~data;
  endtask
endmodule // cnmr_can_master
`default_nettype wire

// ---- cnmr_ms_timer.sv ----
// Periodic millisecond timer with restart, pulsing once per elapsed period
`timescale 1ns/1ps
`default_nettype none
module cnmr_ms_timer
  import cnmr_pkg::*;
#(
  parameter int CYC_PER_MS = CNMR_CYC_PER_MS,
  parameter int WIDTH      = CNMR_MS_W
) (
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  cnmr_timer_if.timer tmr
);
  localparam int PW = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;

  if (CYC_PER_MS < 1) begin : g_chk
    $error("cnmr_ms_timer: CYC_PER_MS must be at least 1");
  end

  logic [PW-1:0]    presc;
  logic [PW-1:0]    next_presc;
  logic [WIDTH-1:0] ms;
  logic [WIDTH-1:0] next_ms;
  logic             expired;
  logic             next_expired;

  always_comb begin
    next_presc   = presc;
    next_ms      = ms;
    next_expired = 1'b0;
    if (!tmr.run || tmr.restart) begin
      next_presc = '0;
      next_ms    = '0;
    end else if (presc == PW'(CYC_PER_MS - 1)) begin
      next_presc = '0;
      if (ms + WIDTH'(1) >= tmr.period_ms) begin
        next_ms      = '0;
        next_expired = 1'b1;
      end else begin
        next_ms = ms + WIDTH'(1);
      end
    end else begin
      next_presc = presc + PW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      presc   <= '0;
      ms      <= '0;
      expired <= 1'b0;
    end else if (ce) begin
      presc   <= next_presc;
      ms      <= next_ms;
      expired <= next_expired;
    end
  end

  assign tmr.expired = expired;
endmodule // cnmr_ms_timer
`default_nettype wire

// ---- cnmr_pkg.sv ----
// Constants shared by the network management responder and its timers
package cnmr_pkg;

  // Frame identifiers
  localparam logic [10:0] CNMR_NMT_BASE_ID = 11'h700;
  localparam logic [10:0] CNMR_LSS_REQ_ID  = 11'h7e5;
  localparam logic [10:0] CNMR_LSS_RSP_ID  = 11'h7e4;

  // Frame lengths
  localparam logic [3:0]  CNMR_LSS_DLC     = 4'h8;
  localparam logic [3:0]  CNMR_NMT_DLC     = 4'h1;

  // Layer-setting command specifiers
  localparam logic [7:0]  CNMR_CS_SWITCH_GLOBAL = 8'h04;
  localparam logic [7:0]  CNMR_CS_SEL_VENDOR    = 8'h40;
  localparam logic [7:0]  CNMR_CS_SEL_PRODUCT   = 8'h41;
  localparam logic [7:0]  CNMR_CS_SEL_REVISION  = 8'h42;
  localparam logic [7:0]  CNMR_CS_SEL_SERIAL    = 8'h43;
  localparam logic [7:0]  CNMR_CS_SEL_CONFIRM   = 8'h44;
  localparam logic [7:0]  CNMR_CS_CFG_NODE      = 8'h11;

  // Byte 1 values, and the boot-up frame's byte 0
  localparam logic [7:0]  CNMR_MODE_WAIT     = 8'h00;
  localparam logic [7:0]  CNMR_MODE_CONFIG   = 8'h01;
  localparam logic [7:0]  CNMR_ERR_OK        = 8'h00;
  localparam logic [7:0]  CNMR_ERR_BAD_NODE  = 8'h01;
  localparam logic [7:0]  CNMR_NODE_MIN      = 8'h01;
  localparam logic [7:0]  CNMR_NODE_MAX      = 8'h7f;
  localparam logic [7:0]  CNMR_BOOT_BYTE     = 8'h00;

  // Network state codes, the guarding toggle position and the default node number
  localparam logic [6:0]  CNMR_STATE_PREOP   = 7'h7f;
  localparam int          CNMR_TOGGLE_BIT    = 7;
  localparam logic [6:0]  CNMR_NODE_DEFAULT  = 7'h7f;

  // Timing
  localparam int          CNMR_CLK_PERIOD_NS = 10;
  localparam int          CNMR_MS_NS         = 1000000;
  localparam int          CNMR_CYC_PER_MS    = CNMR_MS_NS / CNMR_CLK_PERIOD_NS;

  // Timer widths
  localparam int          CNMR_MS_W          = 16;
  localparam int          CNMR_LIFE_W        = 24;

  typedef enum logic [1:0] {
    CNMR_SEL_IDLE,
    CNMR_SEL_VENDOR,
    CNMR_SEL_PRODUCT,
    CNMR_SEL_REVISION
  } cnmr_sel_type;

endpackage

// ---- cnmr_responder.sv ----
// Network management responder: boot-up, guarding, heartbeat and layer-setting slave
`timescale 1ns/1ps
`default_nettype none
module cnmr_responder
  import cnmr_pkg::*;
#(
  parameter int         CYC_PER_MS   = CNMR_CYC_PER_MS,
  parameter logic [6:0] DEFAULT_NODE = CNMR_NODE_DEFAULT
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic        RX_VALID,
  input  wire logic [10:0] RX_ID,
  input  wire logic        RX_RTR,
  input  wire logic [3:0]  RX_DLC,
  input  wire logic [63:0] RX_DATA,
  output logic             TX_VALID,
  input  wire logic        TX_READY,
  output logic [10:0]      TX_ID,
  output logic [3:0]       TX_DLC,
  output logic [63:0]      TX_DATA,
  input  wire logic [6:0]  NMT_STATE,
  input  wire logic [15:0] GUARD_TIME_MS,
  input  wire logic [7:0]  LIFE_FACTOR,
  input  wire logic [15:0] PRODUCER_TIME_MS,
  input  wire logic [15:0] CONSUMER_TIME_MS,
  input  wire logic [6:0]  CONSUMER_NODE,
  input  wire logic [31:0] VENDOR_ID,
  input  wire logic [31:0] PRODUCT_CODE,
  input  wire logic [31:0] REVISION_NUMBER,
  input  wire logic [31:0] SERIAL_NUMBER,
  output logic             GUARD_ERROR,
  output logic             HB_ERROR,
  output logic             LSS_CONFIG_MODE,
  output logic [6:0]       ASSIGNED_NODE_NUMBER
);

  if (CYC_PER_MS < 1) begin : g_chk
    $error("cnmr_responder: CYC_PER_MS must be at least 1");
  end

  function automatic logic [10:0] nmt_id(input logic [6:0] node);
    nmt_id = CNMR_NMT_BASE_ID + {4'h0, node};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Frame decode

  logic [7:0]  rx_cs;
  logic [7:0]  rx_b1;
  logic [31:0] rx_word;
  logic        rx_lss;
  logic        rx_guard;
  logic        rx_hb;

  assign rx_cs    = RX_DATA[7:0];
  assign rx_b1    = RX_DATA[15:8];
  assign rx_word  = RX_DATA[39:8];
  // Short layer-setting frames are dropped rather than half-decoded
  assign rx_lss   = RX_VALID && !RX_RTR && RX_ID == CNMR_LSS_REQ_ID
                    && RX_DLC == CNMR_LSS_DLC;
  assign rx_guard = RX_VALID && RX_RTR && RX_ID == nmt_id(ASSIGNED_NODE_NUMBER);
  assign rx_hb    = RX_VALID && !RX_RTR && RX_ID == nmt_id(CONSUMER_NODE);

  //////////////////////////////////////////////////////////////////////////////
  // Timers

  cnmr_timer_if #(.WIDTH(CNMR_MS_W))   prod_t ();
  cnmr_timer_if #(.WIDTH(CNMR_MS_W))   cons_t ();
  cnmr_timer_if #(.WIDTH(CNMR_LIFE_W)) life_t ();

  logic guard_armed;
  logic cons_run;

  assign prod_t.run       = PRODUCER_TIME_MS != 16'h0000;
  assign prod_t.restart   = 1'b0;
  assign prod_t.period_ms = PRODUCER_TIME_MS;

  assign cons_run         = CONSUMER_TIME_MS != 16'h0000 && CONSUMER_NODE != 7'h00;
  assign cons_t.run       = cons_run;
  assign cons_t.restart   = rx_hb;
  assign cons_t.period_ms = CONSUMER_TIME_MS;

  assign life_t.period_ms = GUARD_TIME_MS * {16'h0000, LIFE_FACTOR};
  assign life_t.run       = guard_armed && life_t.period_ms != 24'h000000;
  assign life_t.restart   = rx_guard;

  cnmr_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .WIDTH(CNMR_MS_W)) u_prod (
    .clk (MCLK),
    .rst (RST),
    .ce  (CE),
    .tmr (prod_t)
  );

  cnmr_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .WIDTH(CNMR_MS_W)) u_cons (
    .clk (MCLK),
    .rst (RST),
    .ce  (CE),
    .tmr (cons_t)
  );

  cnmr_ms_timer #(.CYC_PER_MS(CYC_PER_MS), .WIDTH(CNMR_LIFE_W)) u_life (
    .clk (MCLK),
    .rst (RST),
    .ce  (CE),
    .tmr (life_t)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Supervision

  logic next_guard_armed;
  logic next_guard_error;
  logic next_hb_error;

  always_comb begin
    next_guard_armed = guard_armed || rx_guard;
    next_guard_error = GUARD_ERROR;
    if (rx_guard) begin
      next_guard_error = 1'b0;
    end
    // Expiry is tested last so a late poll in the same cycle still flags
    if (life_t.expired) begin
      next_guard_error = 1'b1;
    end
    next_hb_error = HB_ERROR;
    if (!cons_run || rx_hb) begin
      next_hb_error = 1'b0;
    end
    if (cons_t.expired) begin
      next_hb_error = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      guard_armed <= 1'b0;
      GUARD_ERROR <= 1'b0;
      HB_ERROR    <= 1'b0;
    end else if (CE) begin
      guard_armed <= next_guard_armed;
      GUARD_ERROR <= next_guard_error;
      HB_ERROR    <= next_hb_error;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Layer-setting slave

  cnmr_sel_type sel;
  cnmr_sel_type next_sel;
  logic         next_config;
  logic [6:0]   next_node;
  logic         lss_fire;
  logic [7:0]   lss_cs;
  logic [7:0]   lss_b1;

  always_comb begin
    next_sel    = sel;
    next_config = LSS_CONFIG_MODE;
    next_node   = ASSIGNED_NODE_NUMBER;
    lss_fire    = 1'b0;
    lss_cs      = rx_cs;
    lss_b1      = CNMR_ERR_OK;
    if (rx_lss) begin
      case (rx_cs)
        CNMR_CS_SWITCH_GLOBAL: begin
          next_sel = CNMR_SEL_IDLE;
          if (rx_b1 == CNMR_MODE_WAIT) begin
            next_config = 1'b0;
          end else if (rx_b1 == CNMR_MODE_CONFIG) begin
            next_config = 1'b1;
          end
        end
        CNMR_CS_SEL_VENDOR: begin
          next_sel = (rx_word == VENDOR_ID) ? CNMR_SEL_VENDOR : CNMR_SEL_IDLE;
        end
        CNMR_CS_SEL_PRODUCT: begin
          next_sel = (sel == CNMR_SEL_VENDOR && rx_word == PRODUCT_CODE) ?
                     CNMR_SEL_PRODUCT : CNMR_SEL_IDLE;
        end
        CNMR_CS_SEL_REVISION: begin
          next_sel = (sel == CNMR_SEL_PRODUCT && rx_word == REVISION_NUMBER) ?
                     CNMR_SEL_REVISION : CNMR_SEL_IDLE;
        end
        CNMR_CS_SEL_SERIAL: begin
          next_sel = CNMR_SEL_IDLE;
          if (sel == CNMR_SEL_REVISION && rx_word == SERIAL_NUMBER) begin
            next_config = 1'b1;
            lss_fire    = 1'b1;
            lss_cs      = CNMR_CS_SEL_CONFIRM;
          end
        end
        CNMR_CS_CFG_NODE: begin
          // Wait mode drops the request without a reply
          if (LSS_CONFIG_MODE) begin
            lss_fire = 1'b1;
            if (rx_b1 >= CNMR_NODE_MIN && rx_b1 <= CNMR_NODE_MAX) begin
              next_node = rx_b1[6:0];
              lss_b1    = CNMR_ERR_OK;
            end else begin
              lss_b1 = CNMR_ERR_BAD_NODE;
            end
          end
        end
        default: begin
          next_sel = sel;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      sel                  <= CNMR_SEL_IDLE;
      LSS_CONFIG_MODE      <= 1'b0;
      ASSIGNED_NODE_NUMBER <= DEFAULT_NODE;
    end else if (CE) begin
      sel                  <= next_sel;
      LSS_CONFIG_MODE      <= next_config;
      ASSIGNED_NODE_NUMBER <= next_node;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit arbitration: boot-up, layer-setting, guard reply, heartbeat

  logic        boot_pend;
  logic        lss_pend;
  logic        guard_pend;
  logic        hb_pend;
  logic [7:0]  lss_cs_q;
  logic [7:0]  lss_b1_q;
  logic        toggle;
  logic [6:0]  prev_state;
  logic        next_boot_pend;
  logic        next_lss_pend;
  logic        next_guard_pend;
  logic        next_hb_pend;
  logic [7:0]  next_lss_cs_q;
  logic [7:0]  next_lss_b1_q;
  logic        next_toggle;
  logic        next_tx_valid;
  logic [10:0] next_tx_id;
  logic [3:0]  next_tx_dlc;
  logic [63:0] next_tx_data;
  logic        boot_set;
  logic        slot;

  assign boot_set = NMT_STATE == CNMR_STATE_PREOP && prev_state != CNMR_STATE_PREOP;
  assign slot     = !TX_VALID || TX_READY;

  always_comb begin
    next_boot_pend  = boot_pend;
    next_lss_pend   = lss_pend;
    next_guard_pend = guard_pend;
    next_hb_pend    = hb_pend;
    next_lss_cs_q   = lss_cs_q;
    next_lss_b1_q   = lss_b1_q;
    next_toggle     = toggle;
    next_tx_valid   = TX_VALID && !TX_READY;
    next_tx_id      = TX_ID;
    next_tx_dlc     = TX_DLC;
    next_tx_data    = TX_DATA;
    // A frame handed over is done; nothing waits for an acknowledgement
    if (slot) begin
      if (boot_pend) begin
        next_boot_pend = 1'b0;
        next_tx_valid  = 1'b1;
        next_tx_id     = nmt_id(ASSIGNED_NODE_NUMBER);
        next_tx_dlc    = CNMR_NMT_DLC;
        next_tx_data   = {56'h0, CNMR_BOOT_BYTE};
      end else if (lss_pend) begin
        next_lss_pend = 1'b0;
        next_tx_valid = 1'b1;
        next_tx_id    = CNMR_LSS_RSP_ID;
        next_tx_dlc   = CNMR_LSS_DLC;
        next_tx_data  = {48'h0, lss_b1_q, lss_cs_q};
      end else if (guard_pend) begin
        next_guard_pend = 1'b0;
        next_toggle     = ~toggle;
        next_tx_valid   = 1'b1;
        next_tx_id      = nmt_id(ASSIGNED_NODE_NUMBER);
        next_tx_dlc     = CNMR_NMT_DLC;
        next_tx_data    = {56'h0, toggle, NMT_STATE};
      end else if (hb_pend) begin
        next_hb_pend  = 1'b0;
        next_tx_valid = 1'b1;
        next_tx_id    = nmt_id(ASSIGNED_NODE_NUMBER);
        next_tx_dlc   = CNMR_NMT_DLC;
        next_tx_data  = {56'h0, 1'b0, NMT_STATE};
      end
    end
    // New events are applied after the hand-over so one arriving in the hand-over cycle is not lost
    if (boot_set) begin
      next_boot_pend = 1'b1;
    end
    if (lss_fire) begin
      next_lss_pend = 1'b1;
      next_lss_cs_q = lss_cs;
      next_lss_b1_q = lss_b1;
    end
    if (rx_guard) begin
      next_guard_pend = 1'b1;
    end
    if (prod_t.expired) begin
      next_hb_pend = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      boot_pend  <= 1'b0;
      lss_pend   <= 1'b0;
      guard_pend <= 1'b0;
      hb_pend    <= 1'b0;
      lss_cs_q   <= 8'h00;
      lss_b1_q   <= 8'h00;
      toggle     <= 1'b0;
      prev_state <= 7'h00;
      TX_VALID   <= 1'b0;
      TX_ID      <= 11'h000;
      TX_DLC     <= 4'h0;
      TX_DATA    <= 64'h0;
    end else if (CE) begin
      boot_pend  <= next_boot_pend;
      lss_pend   <= next_lss_pend;
      guard_pend <= next_guard_pend;
      hb_pend    <= next_hb_pend;
      lss_cs_q   <= next_lss_cs_q;
      lss_b1_q   <= next_lss_b1_q;
      toggle     <= next_toggle;
      prev_state <= NMT_STATE;
      TX_VALID   <= next_tx_valid;
      TX_ID      <= next_tx_id;
      TX_DLC     <= next_tx_dlc;
      TX_DATA    <= next_tx_data;
    end
  end

endmodule // cnmr_responder
`default_nettype wire

// ---- cnmr_responder_sva.sv ----
// Port-level assertion checker for the network management responder
`timescale 1ns/1ps
`default_nettype none
module cnmr_responder_sva
  import cnmr_pkg::*;
(
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        CE,
  input wire logic        RX_VALID,
  input wire logic [10:0] RX_ID,
  input wire logic        RX_RTR,
  input wire logic [3:0]  RX_DLC,
  input wire logic [63:0] RX_DATA,
  input wire logic        TX_VALID,
  input wire logic        TX_READY,
  input wire logic [10:0] TX_ID,
  input wire logic [3:0]  TX_DLC,
  input wire logic [63:0] TX_DATA,
  input wire logic [6:0]  NMT_STATE,
  input wire logic [15:0] PRODUCER_TIME_MS,
  input wire logic [15:0] CONSUMER_TIME_MS,
  input wire logic        HB_ERROR,
  input wire logic        LSS_CONFIG_MODE,
  input wire logic [6:0]  ASSIGNED_NODE_NUMBER
);
  logic        tog;
  logic [7:0]  b1;
  logic        lss_rx;
  logic        cfg_rx;
  logic [10:0] own_id;

  assign own_id = CNMR_NMT_BASE_ID + {4'h0, ASSIGNED_NODE_NUMBER};
  assign lss_rx = CE && RX_VALID && !RX_RTR && RX_ID == CNMR_LSS_REQ_ID && RX_DLC == CNMR_LSS_DLC;
  assign cfg_rx = lss_rx && RX_DATA[7:0] == CNMR_CS_CFG_NODE;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////////
  // Guard toggle model: boot frames (byte 0x00) and heartbeats are left out,
  // which only works while heartbeat stays off during guarding
  always_ff @(posedge MCLK) begin
    if (RST)
      tog <= 1'b0;
    else if (TX_VALID && TX_READY && TX_ID == own_id && PRODUCER_TIME_MS == 16'h0
             && TX_DATA[7:0] != 8'h00)
      tog <= ~tog;
  end

  always_ff @(posedge MCLK) begin
    if (RST)
      b1 <= 8'h00;
    else if (lss_rx)
      b1 <= RX_DATA[15:8];
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_boot_frame: assert property (CE && NMT_STATE == CNMR_STATE_PREOP
    && $past(NMT_STATE) != CNMR_STATE_PREOP
    |-> ##[1:20] TX_VALID && TX_ID == own_id && TX_DLC == CNMR_NMT_DLC && TX_DATA[7:0] == 8'h00)
    else $error("boot frame missing");
  a_guard_reply: assert property (CE && RX_VALID && RX_RTR && RX_ID == own_id
    |-> ##[2:20] TX_VALID && TX_ID == own_id && TX_DATA[6:0] == NMT_STATE)
    else $error("guard reply missing");
  a_guard_toggle: assert property (TX_VALID && TX_ID == own_id && PRODUCER_TIME_MS == 16'h0
    && TX_DATA[7:0] != 8'h00 |-> TX_DATA[CNMR_TOGGLE_BIT] == tog)
    else $error("guard toggle wrong");
  a_tx_hold: assert property (TX_VALID && !TX_READY
    |=> TX_VALID && $stable(TX_ID) && $stable(TX_DATA) && $stable(TX_DLC))
    else $error("frame dropped before taken");
  a_lss_len: assert property (TX_VALID && TX_ID == CNMR_LSS_RSP_ID
    |-> TX_DLC == CNMR_LSS_DLC)
    else $error("reply length wrong");
  a_global_mode: assert property (lss_rx && RX_DATA[7:0] == CNMR_CS_SWITCH_GLOBAL
    && RX_DATA[15:9] == 7'h0 |=> LSS_CONFIG_MODE == $past(RX_DATA[8]))
    else $error("global switch mode wrong");
  a_mode_hold: assert property (!lss_rx |=> $stable(LSS_CONFIG_MODE))
    else $error("mode changed without command");
  a_node_set: assert property (cfg_rx && LSS_CONFIG_MODE && RX_DATA[15:8] >= CNMR_NODE_MIN
    && RX_DATA[15:8] <= CNMR_NODE_MAX |=> ASSIGNED_NODE_NUMBER == $past(RX_DATA[14:8]))
    else $error("node not assigned");
  a_node_kept: assert property (cfg_rx && (!LSS_CONFIG_MODE
    || RX_DATA[15:8] == 8'h00 || RX_DATA[15]) |=> $stable(ASSIGNED_NODE_NUMBER))
    else $error("node changed wrongly");
  a_cfg_reply: assert property (cfg_rx && LSS_CONFIG_MODE |-> ##[2:20] TX_VALID
    && TX_ID == CNMR_LSS_RSP_ID && TX_DATA == {48'h0, (b1 >= CNMR_NODE_MIN
    && b1 <= CNMR_NODE_MAX) ? CNMR_ERR_OK : CNMR_ERR_BAD_NODE, CNMR_CS_CFG_NODE})
    else $error("node reply wrong");
  a_sel_confirm: assert property (TX_VALID && TX_ID == CNMR_LSS_RSP_ID
    && TX_DATA[7:0] == CNMR_CS_SEL_CONFIRM |-> TX_DATA[63:8] == 56'h0 && LSS_CONFIG_MODE)
    else $error("selective confirm wrong");
  a_hb_clear: assert property (CONSUMER_TIME_MS == 16'h0 ##1 CONSUMER_TIME_MS == 16'h0
    |=> !HB_ERROR)
    else $error("heartbeat error not cleared");
endmodule // cnmr_responder_sva

bind cnmr_responder cnmr_responder_sva u_sva (
  .MCLK(MCLK), .RST(RST), .CE(CE), .RX_VALID(RX_VALID), .RX_ID(RX_ID), .RX_RTR(RX_RTR),
  .RX_DLC(RX_DLC), .RX_DATA(RX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
  .TX_ID(TX_ID), .TX_DLC(TX_DLC), .TX_DATA(TX_DATA), .NMT_STATE(NMT_STATE),
  .PRODUCER_TIME_MS(PRODUCER_TIME_MS), .CONSUMER_TIME_MS(CONSUMER_TIME_MS),
  .HB_ERROR(HB_ERROR), .LSS_CONFIG_MODE(LSS_CONFIG_MODE),
  .ASSIGNED_NODE_NUMBER(ASSIGNED_NODE_NUMBER)
);
`default_nettype wire

// ---- cnmr_tb.sv ----
// Self-checking testbench for the network management responder
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cnmr_pkg::*;
;
  localparam int CPM = 10;
  // Identity words are arbitrary
  localparam logic [31:0] VEND = 32'h1a2b3c4d;
  localparam logic [31:0] PROD = 32'h00c0ffee;
  localparam logic [31:0] REV  = 32'h00010002;
  localparam logic [31:0] SER  = 32'h5eed0001;

  logic        mclk;
  logic        rst;
  logic        ce;
  logic        slow;
  logic        rx_valid;
  logic [10:0] rx_id;
  logic        rx_rtr;
  logic [3:0]  rx_dlc;
  logic [63:0] rx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic [10:0] tx_id;
  logic [3:0]  tx_dlc;
  logic [63:0] tx_data;
  logic [6:0]  nmt_state;
  logic [15:0] guard_ms;
  logic [7:0]  life;
  logic [15:0] prod_ms;
  logic [15:0] cons_ms;
  logic [6:0]  cons_node;
  logic        guard_error;
  logic        hb_error;
  logic        cfg_mode;
  logic [6:0]  node;
  int          n_mismatch = 0;
  int          check_count = 0;

  cnmr_responder #(.CYC_PER_MS(CPM)) uut (
    .MCLK(mclk), .RST(rst), .CE(ce), .RX_VALID(rx_valid), .RX_ID(rx_id), .RX_RTR(rx_rtr),
    .RX_DLC(rx_dlc), .RX_DATA(rx_data), .TX_VALID(tx_valid), .TX_READY(tx_ready),
    .TX_ID(tx_id), .TX_DLC(tx_dlc), .TX_DATA(tx_data), .NMT_STATE(nmt_state),
    .GUARD_TIME_MS(guard_ms), .LIFE_FACTOR(life), .PRODUCER_TIME_MS(prod_ms),
    .CONSUMER_TIME_MS(cons_ms), .CONSUMER_NODE(cons_node), .VENDOR_ID(VEND),
    .PRODUCT_CODE(PROD), .REVISION_NUMBER(REV), .SERIAL_NUMBER(SER),
    .GUARD_ERROR(guard_error), .HB_ERROR(hb_error), .LSS_CONFIG_MODE(cfg_mode),
    .ASSIGNED_NODE_NUMBER(node));

  cnmr_can_master m (
    .mclk(mclk), .slow(slow), .rx_valid(rx_valid), .rx_id(rx_id), .rx_rtr(rx_rtr),
    .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic timed_out;
    n_mismatch++;
    $display("wrong value at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    finish_test;
  endtask

  task automatic wait_frame(input int max);
    int n0;
    n0 = m.n_rx;
    for (int i = 0; i < max; i++) begin
      cyc(1);
      if (m.n_rx != n0)
        return;
    end
    timed_out;
  endtask

  task automatic wait_err(input logic g, input logic v, input int max);
    for (int i = 0; i < max; i++) begin
      cyc(1);
      if ((g ? guard_error : hb_error) === v)
        return;
    end
    timed_out;
  endtask

  task automatic no_frame(input int n);
    int n0;
    n0 = m.n_rx;
    cyc(n);
    chk(64'(m.n_rx), 64'(n0));
  endtask

  task automatic exp_frame(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
    chk(64'(m.got_id), 64'(id));
    chk(64'(m.got_dlc), 64'(dlc));
    chk(m.got_data, d);
  endtask

  task automatic lss(input logic [7:0] cs, input logic [31:0] w);
    m.send(CNMR_LSS_REQ_ID, 1'b0, CNMR_LSS_DLC, {24'h0, w, cs});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_boot;
    chk(64'(cfg_mode), 64'h0);
    chk(64'(node), 64'h7f);
    no_frame(5);
    nmt_state = CNMR_STATE_PREOP;
    wait_frame(8);
    exp_frame(11'h77f, CNMR_NMT_DLC, 64'h0);
    no_frame(30);
    $display("test boot done");
  endtask

  task automatic t_global;
    lss(CNMR_CS_SWITCH_GLOBAL, 32'h01);
    chk(64'(cfg_mode), 64'h1);
    lss(CNMR_CS_SWITCH_GLOBAL, 32'h02);
    chk(64'(cfg_mode), 64'h1);
    lss(CNMR_CS_SWITCH_GLOBAL, 32'h00);
    chk(64'(cfg_mode), 64'h0);
    ce = 1'b0;
    lss(CNMR_CS_SWITCH_GLOBAL, 32'h01);
    ce = 1'b1;
    chk(64'(cfg_mode), 64'h0);
    no_frame(8);
    lss(CNMR_CS_CFG_NODE, 32'h05);
    chk(64'(node), 64'h7f);
    no_frame(10);
    $display("test switch done");
  endtask

  task automatic t_selective;
    slow = 1'b1;
    lss(CNMR_CS_SEL_VENDOR, VEND);
    lss(CNMR_CS_SEL_PRODUCT, PROD);
    lss(CNMR_CS_SEL_REVISION, REV);
    lss(CNMR_CS_SEL_SERIAL, SER ^ 32'h1);
    no_frame(10);
    chk(64'(cfg_mode), 64'h0);
    lss(CNMR_CS_SEL_VENDOR, VEND);
    lss(CNMR_CS_SEL_PRODUCT, PROD);
    lss(CNMR_CS_SEL_REVISION, REV);
    lss(CNMR_CS_SEL_SERIAL, SER);
    wait_frame(20);
    exp_frame(CNMR_LSS_RSP_ID, CNMR_LSS_DLC, {56'h0, CNMR_CS_SEL_CONFIRM});
    chk(64'(cfg_mode), 64'h1);
    $display("test selective done");
  endtask

  task automatic t_node;
    logic [7:0] bad [2];
    bad = '{8'h00, 8'h80};
    lss(CNMR_CS_CFG_NODE, 32'h05);
    wait_frame(20);
    exp_frame(CNMR_LSS_RSP_ID, CNMR_LSS_DLC, {48'h0, CNMR_ERR_OK, CNMR_CS_CFG_NODE});
    chk(64'(node), 64'h05);
    slow = 1'b0;
    foreach (bad[i]) begin
      lss(CNMR_CS_CFG_NODE, {24'h0, bad[i]});
      wait_frame(20);
      exp_frame(CNMR_LSS_RSP_ID, CNMR_LSS_DLC,
                {48'h0, CNMR_ERR_BAD_NODE, CNMR_CS_CFG_NODE});
      chk(64'(node), 64'h05);
    end
    $display("test node done");
  endtask

  task automatic t_heartbeat;
    time t1;
    nmt_state = 7'h05;
    prod_ms = 16'd3;
    wait_frame(50);
    t1 = m.t_rx;
    exp_frame(11'h705, CNMR_NMT_DLC, 64'h05);
    wait_frame(50);
    chk(64'((m.t_rx - t1) / 10), 64'(3 * CPM));
    prod_ms = 16'd0;
    no_frame(80);
    $display("test heartbeat done");
  endtask

  task automatic t_guard;
    guard_ms = 16'd2;
    life = 8'd3;
    for (int k = 0; k < 3; k++) begin
      m.send(11'h705, 1'b1, 4'h0, 64'h0);
      wait_frame(10);
      exp_frame(11'h705, CNMR_NMT_DLC, {56'h0, k[0], 7'h05});
    end
    cyc(50);
    chk(64'(guard_error), 64'h0);
    wait_err(1'b1, 1'b1, 30);
    m.send(11'h705, 1'b1, 4'h0, 64'h0);
    wait_frame(10);
    chk(64'(guard_error), 64'h0);
    guard_ms = 16'd0;
    $display("test guard done");
  endtask

  task automatic t_consumer;
    cons_node = 7'h22;
    cons_ms = 16'd4;
    cyc(30);
    chk(64'(hb_error), 64'h0);
    wait_err(1'b0, 1'b1, 20);
    m.send(11'h722, 1'b0, 4'h1, 64'h05);
    wait_err(1'b0, 1'b0, 5);
    wait_err(1'b0, 1'b1, 50);
    cons_ms = 16'd0;
    wait_err(1'b0, 1'b0, 5);
    $display("test consumer done");
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    slow = 1'b0;
    nmt_state = 7'h00;
    guard_ms = 16'h0;
    life = 8'h0;
    prod_ms = 16'h0;
    cons_ms = 16'h0;
    cons_node = 7'h0;
    repeat (10) @(posedge mclk);
    #1;
    rst = 1'b0;
    cyc(1);
    t_boot;
    t_global;
    t_selective;
    t_node;
    t_heartbeat;
    t_guard;
    t_consumer;
    finish_test;
  end
endmodule // testbench
`default_nettype wire

// ---- cnmr_timer_if.sv ----
// Control and expiry signals between the responder and one millisecond timer
`timescale 1ns/1ps
`default_nettype none
interface cnmr_timer_if #(parameter int WIDTH = 16) ();
  logic             run;
  logic             restart;
  logic [WIDTH-1:0] period_ms;
  logic             expired;

  modport timer (input run, input restart, input period_ms, output expired);
  modport user  (output run, output restart, output period_ms, input expired);
endinterface
`default_nettype wire
